// file: spiie_top.v
/*
  Interrupt enable block of a serial peripheral interface with an APB
  register slave, receive and transmit holding registers, status flags
  and a single level interrupt output.
  Assumes a shift engine on ref_clk drives the push, pull and start
  strobes, and slave select pins arrive asynchronously, active low.
*/
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "spiie_defs.vh"

// Overview of operation
// - Each enable bit sits at the position of the flag it gates.
// - Reading the enable-set register returns all implemented enables.
// - Writing ones to the enable-set register sets those enables.
// - Writing the enable-set register never clears an enable.
// - Bit 0 enables the receive data available interrupt.
// - Bit 1 enables the transmit holding register free interrupt.
// - Bit 2 enables the receiver overrun interrupt.
// - Slave mode flags overrun when new data meets unread receive data.
// - Master mode refuses a new transfer that would overrun the receiver.
// - Bit 3 enables the transmitter underrun interrupt.
// - Slave mode flags underrun when sending with no data loaded.
// - All enable bits read zero after reset.
// - Bit 4 enables the interrupt on any select becoming asserted while none was.
// - Bit 5 enables the interrupt on all selects released.
// - Writing one to the enable-clear register clears that enable.
// - Reading the receive data register clears the data available flag.
module spiie_top #(
  parameter DATA_W = `SPIIE_DATA_W,
  parameter NSEL   = `SPIIE_NSEL
) (
  // Clock and reset
  input  wire              ref_clk,
  input  wire              rst,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       paddr,
  input  wire [31:0]       pwdata,
  output wire [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  // Interrupt
  output wire              irq,
  // Shift engine, receive side
  input  wire              rx_push,
  input  wire [DATA_W-1:0] rx_push_data,
  // Shift engine, transmit side
  input  wire              tx_pull,
  output wire [DATA_W-1:0] tx_pull_data,
  output wire              tx_pull_valid,
  // Shift engine, master start handshake
  input  wire              start_req,
  output wire              start_gnt,
  output wire              master_mode,
  // Slave select pins, active low
  input  wire [NSEL-1:0]   ssel_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [5:0]        irq_en_ff;
  reg  [5:0]        nxt_irq_en;
  reg               master_ff;
  reg  [DATA_W-1:0] rx_data_ff;
  reg  [DATA_W-1:0] tx_data_ff;
  reg  [31:0]       prdata_ff;
  reg  [31:0]       nxt_prdata;
  reg  [5:0]        snap_flags_ff;
  reg               irq_ff;
  wire [5:0]        flags;
  wire [5:0]        stat_clr;
  wire [NSEL-1:0]   ssel_n_sync;
  wire              sel_any;
  wire              setup_ph;
  wire              access_ph;
  wire              wr_acc;
  wire              rd_acc;
  wire              mapped;
  wire              rx_clr;
  wire              tx_load;
  wire              rx_take;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function hit;
    input [31:0] addr;
    input [31:0] reg_addr;
    begin
      hit = (addr == reg_addr);
    end
  endfunction

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc    = access_ph & pwrite;
  assign rd_acc    = access_ph & ~pwrite;

  assign mapped = hit(paddr, `SPIIE_CTRL_ADDR)
                | hit(paddr, `SPIIE_STAT_ADDR)
                | hit(paddr, `SPIIE_ENSET_ADDR)
                | hit(paddr, `SPIIE_ENCLR_ADDR)
                | hit(paddr, `SPIIE_RX_DATA_REG_ADDR)
                | hit(paddr, `SPIIE_TX_DATA_REG_ADDR);

  // Every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata  = prdata_ff;

  // ----------------------------------------------------------------
  // Slave select pins
  // ----------------------------------------------------------------
  spiie_sync #(
    .W (NSEL)
  ) u_sel_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (ssel_n),
    .rst_val  ({NSEL{1'b1}}),
    .sync_out (ssel_n_sync)
  );

  assign sel_any = ~(&ssel_n_sync);

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle, so side effects use the
  // snapshot: an event landing between setup and access is kept.
  assign stat_clr = (rd_acc & hit(paddr, `SPIIE_STAT_ADDR)) ?
                    snap_flags_ff : 6'h00;
  assign rx_clr   = rd_acc & hit(paddr, `SPIIE_RX_DATA_REG_ADDR)
                  & snap_flags_ff[`SPIIE_RXAV_BIT];
  assign tx_load  = wr_acc & hit(paddr, `SPIIE_TX_DATA_REG_ADDR);

  spiie_flags u_flags (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .master   (master_ff),
    .rx_push  (rx_push),
    .rx_clr   (rx_clr),
    .tx_load  (tx_load),
    .tx_pull  (tx_pull),
    .sel_any  (sel_any),
    .stat_clr (stat_clr),
    .flags    (flags)
  );

  // ----------------------------------------------------------------
  // Master start gate
  // ----------------------------------------------------------------
  // A transfer that would land on unread receive data is held off
  assign start_gnt   = start_req & master_ff
                     & ~flags[`SPIIE_RXAV_BIT];
  assign master_mode = master_ff;

  // ----------------------------------------------------------------
  // Receive and transmit holding registers
  // ----------------------------------------------------------------
  // Unread receive data is never overwritten; incoming data is lost
  assign rx_take = rx_push & ~flags[`SPIIE_RXAV_BIT];

  always @(posedge ref_clk) begin
    if (rst) begin
      rx_data_ff <= {DATA_W{1'b0}};
      tx_data_ff <= {DATA_W{1'b0}};
    end else begin
      if (rx_take) begin
        rx_data_ff <= rx_push_data;
      end
      if (tx_load) begin
        tx_data_ff <= pwdata[DATA_W-1:0];
      end
    end
  end

  assign tx_pull_data  = tx_data_ff;
  assign tx_pull_valid = ~flags[`SPIIE_TXSP_BIT];

  // ----------------------------------------------------------------
  // Control and enable registers
  // ----------------------------------------------------------------
  always @* begin
    nxt_irq_en = irq_en_ff;
    if (wr_acc & hit(paddr, `SPIIE_ENSET_ADDR)) begin
      nxt_irq_en = irq_en_ff | pwdata[5:0];
    end
    if (wr_acc & hit(paddr, `SPIIE_ENCLR_ADDR)) begin
      nxt_irq_en = irq_en_ff & ~pwdata[5:0];
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      irq_en_ff <= `SPIIE_EN_RST;
      master_ff <= `SPIIE_CTRL_RST;
    end else begin
      irq_en_ff <= nxt_irq_en;
      if (wr_acc & hit(paddr, `SPIIE_CTRL_ADDR)) begin
        master_ff <= pwdata[`SPIIE_MASTER_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @* begin
    nxt_prdata = 32'h00000000;
    if (hit(paddr, `SPIIE_CTRL_ADDR)) begin
      nxt_prdata[`SPIIE_MASTER_BIT] = master_ff;
    end
    if (hit(paddr, `SPIIE_STAT_ADDR)) begin
      nxt_prdata[5:0] = flags;
    end
    if (hit(paddr, `SPIIE_ENSET_ADDR)) begin
      nxt_prdata[5:0] = irq_en_ff;
    end
    if (hit(paddr, `SPIIE_RX_DATA_REG_ADDR)) begin
      nxt_prdata[DATA_W-1:0] = rx_data_ff;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      prdata_ff     <= 32'h00000000;
      snap_flags_ff <= 6'h00;
    end else if (setup_ph & ~pwrite) begin
      prdata_ff     <= nxt_prdata;
      snap_flags_ff <= flags;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // Registered so the pin never glitches on decode; costs one cycle.
  // Enable word and flag word share one layout, so a bitwise AND pairs
  // each source with its enable.
  always @(posedge ref_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(flags & irq_en_ff);
    end
  end

  assign irq = irq_ff;

endmodule
`default_nettype wire

// file: spiie_defs.vh
/*
  Constants of the interrupt enable block: register byte addresses,
  bit positions of the flags and enables, and reset values.
  Assumes it is included by its bare name from the design files.
*/
`ifndef SPIIE_DEFS_VH
`define SPIIE_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SPIIE_CTRL_ADDR     32'h40058000
`define SPIIE_STAT_ADDR     32'h40058008
`define SPIIE_ENSET_ADDR    32'h4005800C
`define SPIIE_ENCLR_ADDR    32'h40058010
`define SPIIE_RX_DATA_REG_ADDR    32'h40058014
`define SPIIE_TX_DATA_REG_ADDR    32'h4005801C

// ----------------------------------------------------------------
// Flag and enable bit positions (same layout in both words)
// ----------------------------------------------------------------
`define SPIIE_RXAV_BIT      0
`define SPIIE_TXSP_BIT      1
`define SPIIE_RX_OVERRUN_FLAG_BIT      2
`define SPIIE_TX_UNDERRUN_FLAG_BIT      3
`define SPIIE_SSA_BIT       4
`define SPIIE_SSD_BIT       5
`define SPIIE_NFLAG         6
`define SPIIE_MASTER_BIT    0

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define SPIIE_EN_RST        6'h00
`define SPIIE_STICKY_RST    4'h0
`define SPIIE_CTRL_RST      1'h0
`define SPIIE_DATA_W        16
`define SPIIE_NSEL          4

`endif

// file: spiie_sync.v
/*
  Two flip-flop synchroniser for a bus of levels.
  Assumes each bit changes slowly against ref_clk; no bus coherence.
*/
`timescale 1ns/1ps
`default_nettype none

module spiie_sync #(
  parameter W = 4
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         rst,
  // Levels
  input  wire [W-1:0] async_in,
  input  wire [W-1:0] rst_val,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  always @(posedge ref_clk) begin
    if (rst) begin
      meta_ff <= rst_val;
      sync_ff <= rst_val;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule
`default_nettype wire

// file: spiie_flags.v
/*
  Status flags of the serial interface: receive data available,
  transmit space, overrun, underrun, select assert and release.
  Assumes push, pull and load strobes are single-cycle ref_clk pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spiie_defs.vh"

module spiie_flags (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // Events from the data path
  input  wire       master,
  input  wire       rx_push,
  input  wire       rx_clr,
  input  wire       tx_load,
  input  wire       tx_pull,
  input  wire       sel_any,
  // Software clear of sticky bits, one per flag position
  input  wire [5:0] stat_clr,
  // Flag word
  output wire [5:0] flags
);

  reg       rx_full_ff;
  reg       tx_full_ff;
  reg [3:0] sticky_ff;
  reg       sel_prev_ff;
  reg       nxt_rx_full;
  reg       nxt_tx_full;
  reg [3:0] nxt_sticky;
  wire      ov_evt;
  wire      ur_evt;
  wire      ssa_evt;
  wire      ssd_evt;

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  assign ov_evt  = rx_push & rx_full_ff & ~master;
  assign ur_evt  = tx_pull & ~tx_full_ff & ~master;
  assign ssa_evt = sel_any & ~sel_prev_ff;
  assign ssd_evt = ~sel_any & sel_prev_ff;

  // ----------------------------------------------------------------
  // Next state; a set always wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always @* begin
    nxt_rx_full = rx_full_ff;
    if (rx_clr) begin
      nxt_rx_full = 1'b0;
    end
    if (rx_push) begin
      nxt_rx_full = 1'b1;
    end
    nxt_tx_full = tx_full_ff;
    if (tx_pull) begin
      nxt_tx_full = 1'b0;
    end
    if (tx_load) begin
      nxt_tx_full = 1'b1;
    end
    nxt_sticky = (sticky_ff & ~stat_clr[5:2])
               | {ssd_evt, ssa_evt, ur_evt, ov_evt};
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rx_full_ff  <= 1'b0;
      tx_full_ff  <= 1'b0;
      sticky_ff   <= `SPIIE_STICKY_RST;
      sel_prev_ff <= 1'b0;
    end else begin
      rx_full_ff  <= nxt_rx_full;
      tx_full_ff  <= nxt_tx_full;
      sticky_ff   <= nxt_sticky;
      sel_prev_ff <= sel_any;
    end
  end

  assign flags = {sticky_ff, ~tx_full_ff, rx_full_ff};

endmodule
`default_nettype wire

// file: spiie_props.sv
/*
  Checker for the interrupt enable block: mirrors the enable word
  from APB writes and ties irq, read data and grant to their causes.
  Assumes zero wait state APB; bound to spiie_top below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spiie_defs.vh"

module spiie_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Interrupt and engine
  input wire logic        irq,
  input wire logic        rx_push,
  input wire logic        tx_pull,
  input wire logic        tx_pull_valid,
  input wire logic        start_req,
  input wire logic        start_gnt,
  input wire logic        master_mode
);
  // ----------------------------------------------------------------
  // Enable mirror
  // ----------------------------------------------------------------
  logic [5:0] en_ff;
  logic [5:0] nxt_en;
  logic       wr_acc;
  logic       rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign nxt_en = (wr_acc && paddr == `SPIIE_ENSET_ADDR) ? (en_ff | pwdata[5:0]) :
                  (wr_acc && paddr == `SPIIE_ENCLR_ADDR) ? (en_ff & ~pwdata[5:0]) : en_ff;
  always_ff @(posedge ref_clk) begin
    en_ff <= rst ? 6'h00 : nxt_en;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_reset_quiet: assert property ($fell(rst) |-> !irq && !master_mode && !start_gnt)
    else $error("irq or mode active right after reset");
  chk_enset_read: assert property (rd_acc && paddr == `SPIIE_ENSET_ADDR
    |-> prdata == {26'h0, en_ff})
    else $error("enable read does not match written enables");
  chk_irq_off: assert property (en_ff == 6'h00 |=> !irq)
    else $error("irq with no enable set");
  chk_rx_irq: assert property (rx_push && en_ff[0] |-> ##2 irq)
    else $error("no irq after receive push");
  chk_tx_irq: assert property (en_ff[1] && !tx_pull_valid |=> irq)
    else $error("no irq while transmit holding register empty");
  chk_under_irq: assert property (tx_pull && !tx_pull_valid && !master_mode && en_ff[3]
    |-> ##2 irq)
    else $error("no irq after slave underrun");
  chk_grant_master: assert property (start_gnt |-> master_mode && start_req)
    else $error("start granted outside master request");
  chk_rx_clear: assert property (rd_acc && paddr == `SPIIE_RX_DATA_REG_ADDR && en_ff == 6'h01
    && !rx_push |=> ##1 !irq)
    else $error("irq stays after receive data read");
endmodule

bind spiie_top spiie_props i_props (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .irq(irq), .rx_push(rx_push),
  .tx_pull(tx_pull), .tx_pull_valid(tx_pull_valid), .start_req(start_req),
  .start_gnt(start_gnt), .master_mode(master_mode)
);
`default_nettype wire

// file: spiie_engine.sv
/*
  Shift engine model: pushes received words, pulls transmit words,
  requests starts and drives the select pins.
  Assumes calls start right after a rising ref_clk edge.
*/
`timescale 1ns/1ps
`default_nettype none

module spiie_engine (
  // Clock
  input  wire logic        ref_clk,
  // Engine strobes
  output var  logic        rx_push,
  output var  logic [15:0] rx_push_data,
  output var  logic        tx_pull,
  output var  logic        start_req,
  // Select pins, active low
  output var  logic [3:0]  ssel_n
);
  // ----------------------------------------------------------------
  // Stimulus tasks
  // ----------------------------------------------------------------
  initial begin
    rx_push = 1'b0;
    rx_push_data = 16'h0000;
    tx_pull = 1'b0;
    start_req = 1'b0;
    ssel_n = 4'hF;
  end
  // Data inverted after release so stale values never look valid
  task push(input logic [15:0] d);
    @(posedge ref_clk) begin rx_push <= 1'b1; rx_push_data <= d; end
    @(posedge ref_clk) begin rx_push <= 1'b0; rx_push_data <= ~d; end
  endtask
  task pull;
    @(posedge ref_clk) tx_pull <= 1'b1;
    @(posedge ref_clk) tx_pull <= 1'b0;
  endtask
  task sel(input logic [3:0] v);
    @(posedge ref_clk) ssel_n <= v;
  endtask
  task req(input logic v);
    @(posedge ref_clk) start_req <= v;
  endtask
endmodule
`default_nettype wire

// file: spi_interrupt_enable_set_bench.sv
/*
  Bench for the interrupt enable block: APB register tests, engine
  events and select pins, checking irq and read data.
  Assumes zero wait state APB slave and the engine model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spiie_defs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module spi_interrupt_enable_set_bench;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        ref_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] rdat;
  logic        serr;
  wire  [31:0] prdata;
  wire  [15:0] rx_push_data;
  wire  [15:0] tx_pull_data;
  wire  [3:0]  ssel_n;
  wire         pready, pslverr, irq, rx_push, tx_pull, tx_pull_valid;
  wire         start_req, start_gnt, master_mode;
  int          err_count = 0;
  int          n_compared = 0;
  // Bus idle and reset asserted from time zero
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
  end
  always #2.5 ref_clk = ~ref_clk;
  spiie_top i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .rx_push(rx_push), .rx_push_data(rx_push_data),
    .tx_pull(tx_pull), .tx_pull_data(tx_pull_data), .tx_pull_valid(tx_pull_valid),
    .start_req(start_req), .start_gnt(start_gnt), .master_mode(master_mode), .ssel_n(ssel_n));
  spiie_engine i_eng (.ref_clk(ref_clk), .rx_push(rx_push), .rx_push_data(rx_push_data),
    .tx_pull(tx_pull), .start_req(start_req), .ssel_n(ssel_n));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk) begin psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; end
    @(posedge ref_clk) penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat & m, e)
  endtask
  // Bounded wait: irq follows its cause within a few cycles
  task wirq(input logic e);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      if (irq === e) break;
    end
    `CHK(irq, e)
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #40000;
    err_count++;
    results();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`SPIIE_ENSET_ADDR, 32'hFFFFFFFF, 32'h0);
    `CHK(irq, 1'b0)
    $display("reset test done");
    apb(1'b1, `SPIIE_ENSET_ADDR, 32'h5);
    apb(1'b1, `SPIIE_ENSET_ADDR, 32'h2);
    rd(`SPIIE_ENSET_ADDR, 32'hFFFFFFFF, 32'h7);
    apb(1'b1, `SPIIE_ENSET_ADDR, 32'hFFFFFFFF);
    rd(`SPIIE_ENSET_ADDR, 32'hFFFFFFFF, 32'h3F);
    apb(1'b1, `SPIIE_ENSET_ADDR, 32'h0);
    rd(`SPIIE_ENSET_ADDR, 32'hFFFFFFFF, 32'h3F);
    apb(1'b1, `SPIIE_ENCLR_ADDR, 32'h3D);
    rd(`SPIIE_ENSET_ADDR, 32'hFFFFFFFF, 32'h2);
    apb(1'b1, 32'h40058020, 32'hFFFFFFFF);
    `CHK(serr, 1'b1)
    rd(`SPIIE_ENSET_ADDR, 32'hFFFFFFFF, 32'h2);
    $display("register test done");
    wirq(1'b1);
    apb(1'b1, `SPIIE_TX_DATA_REG_ADDR, 32'hBEEF);
    wirq(1'b0);
    `CHK(tx_pull_data, 16'hBEEF)
    `CHK(tx_pull_valid, 1'b1)
    i_eng.pull();
    wirq(1'b1);
    apb(1'b1, `SPIIE_ENCLR_ADDR, 32'h3F);
    wirq(1'b0);
    $display("transmit test done");
    apb(1'b1, `SPIIE_ENSET_ADDR, 32'h1);
    i_eng.push(16'h5A5A);
    wirq(1'b1);
    rd(`SPIIE_RX_DATA_REG_ADDR, 32'hFFFF, 32'h5A5A);
    wirq(1'b0);
    apb(1'b1, `SPIIE_ENCLR_ADDR, 32'h1);
    apb(1'b1, `SPIIE_ENSET_ADDR, 32'h4);
    i_eng.push(16'h00A1);
    i_eng.push(16'h00A2);
    wirq(1'b1);
    rd(`SPIIE_STAT_ADDR, 32'h5, 32'h5);
    wirq(1'b0);
    rd(`SPIIE_RX_DATA_REG_ADDR, 32'hFFFF, 32'h00A1);
    apb(1'b1, `SPIIE_ENCLR_ADDR, 32'h4);
    $display("receive test done");
    apb(1'b1, `SPIIE_ENSET_ADDR, 32'h8);
    i_eng.pull();
    wirq(1'b1);
    rd(`SPIIE_STAT_ADDR, 32'h8, 32'h8);
    wirq(1'b0);
    apb(1'b1, `SPIIE_ENCLR_ADDR, 32'h8);
    $display("underrun test done");
    apb(1'b1, `SPIIE_CTRL_ADDR, 32'h1);
    i_eng.push(16'h0011);
    i_eng.req(1'b1);
    @(negedge ref_clk);
    `CHK(start_gnt, 1'b0)
    i_eng.push(16'h0022);
    rd(`SPIIE_STAT_ADDR, 32'h4, 32'h0);
    rd(`SPIIE_RX_DATA_REG_ADDR, 32'hFFFF, 32'h0011);
    @(negedge ref_clk);
    `CHK(start_gnt, 1'b1)
    i_eng.req(1'b0);
    apb(1'b1, `SPIIE_CTRL_ADDR, 32'h0);
    $display("master test done");
    apb(1'b1, `SPIIE_ENSET_ADDR, 32'h10);
    i_eng.sel(4'hE);
    wirq(1'b1);
    rd(`SPIIE_STAT_ADDR, 32'h10, 32'h10);
    wirq(1'b0);
    apb(1'b1, `SPIIE_ENCLR_ADDR, 32'h10);
    apb(1'b1, `SPIIE_ENSET_ADDR, 32'h20);
    i_eng.sel(4'hF);
    wirq(1'b1);
    rd(`SPIIE_STAT_ADDR, 32'h20, 32'h20);
    wirq(1'b0);
    $display("select test done");
    apb(1'b1, `SPIIE_ENSET_ADDR, 32'h3F);
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`SPIIE_ENSET_ADDR, 32'hFFFFFFFF, 32'h0);
    `CHK(irq, 1'b0)
    $display("mid-run reset test done");
    results();
  end
endmodule
`default_nettype wire
